// [src/dcil_pkg.sv]
package dcil_pkg;

   // ----------------------------------------------------------------
   // opcode bytes watched on the fetch cycles
   // ----------------------------------------------------------------
   localparam logic [7:0] OPC_RETURN_FIRST = 8'hED; // first byte of interrupt_return_opcode
   localparam logic [7:0] OPC_RETURN_SECOND = 8'h4D; // second byte of interrupt_return_opcode

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic RST_INT_N = 1'b1;
   localparam logic RST_CHAIN_OUT = 1'b0;
   localparam logic RST_BUS_OE_N = 1'b1;
   localparam logic [7:0] RST_BUS_DATA = 8'h00;
   localparam logic [7:0] RST_FETCH_BYTE = 8'h00;

   // host processor strobes and data bus, all sampled on sys_clk
   typedef struct packed {
      logic opcodeFetchN; // opcode_fetch_n
      logic ioRequestN; // io_request_n
      logic [7:0] data;
   } dcil_host_s;

   // common control fanned out to every source slot
   typedef struct packed {
      logic freeze; // opcode fetch strobe low
      logic ackStart; // first cycle of an acknowledge
      logic returnFirstSeen; // first return byte fetched
      logic returnDone; // second return byte fetched
   } dcil_slot_ctl_s;

   // state of one source slot
   typedef struct packed {
      logic arrived; // event seen, waiting for the strobe to rise
      logic pending;
      logic underService;
   } dcil_slot_state_s;

   // state of the top level
   typedef struct packed {
      logic fetchPrev; // last cycle was an opcode fetch
      logic ackPrev; // last cycle was an acknowledge
      logic ackInPeriod; // acknowledge seen while strobe low
      logic returnFirstSeen;
      logic [7:0] fetchByte;
      logic intN;
      logic chainOut;
      logic [7:0] busData;
      logic busOeN;
   } dcil_top_state_s;

endpackage : dcil_pkg

// [src/dcil_source_slot.sv]
`timescale 1ns/10ps
module dcil_source_slot
   import dcil_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // source event and shared control
   input wire logic reqPulse,
   input wire dcil_slot_ctl_s ctl,
   // chain links
   input wire logic chainIn,
   output logic chainOut,
   // state seen by the top level
   output logic request,
   output logic pending,
   output logic underService
);

   dcil_slot_state_s st_ff;
   dcil_slot_state_s nxt_st;

   // ----------------------------------------------------------------
   // chain links and request
   // ----------------------------------------------------------------
   // pending blocks the chain unless the first return byte was seen
   always_comb begin
      chainOut = chainIn & ~st_ff.underService
         & ~(st_ff.pending & ~ctl.returnFirstSeen);
      request = chainIn & st_ff.pending & ~st_ff.underService;
      pending = st_ff.pending;
      underService = st_ff.underService;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      // events are parked while the fetch strobe is low
      if (!ctl.freeze && st_ff.arrived) begin
         nxt_st.pending = 1'b1;
         nxt_st.arrived = 1'b0;
      end
      if (reqPulse) begin
         nxt_st.arrived = 1'b1; // a new event wins over the transfer
      end
      // acknowledged source: pending to under service
      if (ctl.ackStart && request) begin
         nxt_st.pending = 1'b0;
         nxt_st.underService = 1'b1;
      end
      // chain in high with under service set marks the serviced source
      if (ctl.returnDone && chainIn && st_ff.underService) begin
         nxt_st.underService = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_ack_takes_source: assert property (@(posedge sys_clk) disable iff (srst)
      (ctl.ackStart && request) |=> (underService && !pending && !chainOut))
      else $error("acknowledged source did not enter service");

   a_freeze_parks: assert property (@(posedge sys_clk) disable iff (srst)
      (ctl.freeze && !pending && !(ctl.ackStart && request)) |=> !pending)
      else $error("pending changed while fetch strobe low");

endmodule : dcil_source_slot

// [src/dcil_top.sv]
`timescale 1ns/10ps
// Summary of operation
// - runs on the host processor clock
// - requests service by pulling intN low
// - pending or in service forces chain out low
// - otherwise chain out follows chain in
// - internal source chain inserted in outer chain
// - status frozen while fetch strobe low
// - selected source drives vector during acknowledge
// - first return byte unblocks unacknowledged pendings
// - second return byte ends current service
module dcil_top
   import dcil_pkg::*;
#(
   parameter int NUM_SRC = 8
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // host processor strobes and data
   input wire dcil_host_s hostBus,
   output logic [7:0] busDataOut,
   output logic busOeN,
   // interrupt request to the host
   output logic intN,
   // outer priority chain
   input wire logic chainEnableIn,
   output logic chainEnableOut,
   // interrupt sources, index 0 has the highest priority
   input wire logic [NUM_SRC-1:0] srcEvent,
   input wire logic [7:0] vectorBase
);

   localparam int SW = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // index of the highest priority requester
   function automatic logic [SW-1:0] firstIndex(input logic [NUM_SRC-1:0] vec);
      logic [SW-1:0] idx;
      idx = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (vec[i]) begin
            idx = SW'(i);
         end
      end
      return idx;
   endfunction : firstIndex

   // source index replaces the low bits of the vector base
   function automatic logic [7:0] makeVector(input logic [7:0] base,
                                             input logic [SW-1:0] idx);
      logic [7:0] mask;
      mask = 8'((1 << SW) - 1);
      return (base & ~mask) | (8'(idx) & mask);
   endfunction : makeVector

   dcil_top_state_s st_ff;
   dcil_top_state_s nxt_st;
   dcil_slot_ctl_s slotCtl;

   logic [NUM_SRC:0] chainLink;
   logic [NUM_SRC-1:0] reqVec;
   logic [NUM_SRC-1:0] pendVec;
   logic [NUM_SRC-1:0] iusVec;
   logic inFetch;
   logic ackNow;
   logic ackStart;
   logic fetchEnd;
   logic returnDone;
   logic [7:0] ackVector;

   // ----------------------------------------------------------------
   // host cycle decode
   // ----------------------------------------------------------------
   // acknowledge is fetch strobe and io strobe low together
   always_comb begin
      inFetch = !hostBus.opcodeFetchN && hostBus.ioRequestN;
      ackNow = !hostBus.opcodeFetchN && !hostBus.ioRequestN;
      ackStart = ackNow && !st_ff.ackPrev;
      fetchEnd = hostBus.opcodeFetchN && st_ff.fetchPrev && !st_ff.ackInPeriod;
      returnDone = fetchEnd && st_ff.returnFirstSeen
         && (st_ff.fetchByte == OPC_RETURN_SECOND);
      ackVector = makeVector(vectorBase, firstIndex(reqVec));
   end

   // shared slot control
   always_comb begin
      slotCtl.freeze = !hostBus.opcodeFetchN;
      slotCtl.ackStart = ackStart;
      slotCtl.returnFirstSeen = st_ff.returnFirstSeen;
      slotCtl.returnDone = returnDone;
   end

   // ----------------------------------------------------------------
   // internal source chain
   // ----------------------------------------------------------------
   // top device has its chain input tied high by the system
   assign chainLink[0] = chainEnableIn;

   for (genvar g = 0; g < NUM_SRC; g++) begin : gSlot
      dcil_source_slot uSlot (
         .sys_clk(sys_clk),
         .srst(srst),
         .reqPulse(srcEvent[g]),
         .ctl(slotCtl),
         .chainIn(chainLink[g]),
         .chainOut(chainLink[g+1]),
         .request(reqVec[g]),
         .pending(pendVec[g]),
         .underService(iusVec[g])
      );
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.fetchPrev = inFetch;
      nxt_st.ackPrev = ackNow;
      // an acknowledge period is not an opcode fetch
      if (hostBus.opcodeFetchN) begin
         nxt_st.ackInPeriod = 1'b0;
      end else if (ackNow) begin
         nxt_st.ackInPeriod = 1'b1;
      end
      if (inFetch) begin
         nxt_st.fetchByte = hostBus.data;
      end
      // return opcode tracking, bytes must follow back to back
      if (fetchEnd) begin
         nxt_st.returnFirstSeen = (st_ff.fetchByte == OPC_RETURN_FIRST);
      end
      // request output and outer chain output
      nxt_st.intN = ~(|reqVec);
      nxt_st.chainOut = chainLink[NUM_SRC];
      // vector drive on the data bus during acknowledge
      if (ackStart && (|reqVec)) begin
         nxt_st.busData = ackVector;
         nxt_st.busOeN = 1'b0;
      end else if (!ackNow) begin
         nxt_st.busOeN = 1'b1;
      end
   end

   // single clock, same as the host processor
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_ff.fetchPrev <= 1'b0;
         st_ff.ackPrev <= 1'b0;
         st_ff.ackInPeriod <= 1'b0;
         st_ff.returnFirstSeen <= 1'b0;
         st_ff.fetchByte <= RST_FETCH_BYTE;
         st_ff.intN <= RST_INT_N;
         st_ff.chainOut <= RST_CHAIN_OUT;
         st_ff.busData <= RST_BUS_DATA;
         st_ff.busOeN <= RST_BUS_OE_N;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from flip-flops
   assign intN = st_ff.intN;
   assign chainEnableOut = st_ff.chainOut;
   assign busDataOut = st_ff.busData;
   assign busOeN = st_ff.busOeN;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_int_request: assert property (@(posedge sys_clk) disable iff (srst)
      (|reqVec) |=> !intN)
      else $error("request present but intN high");

   a_chain_blocked: assert property (@(posedge sys_clk) disable iff (srst)
      (|iusVec) |=> !chainEnableOut)
      else $error("chain out high while a source is in service");

   a_chain_follows: assert property (@(posedge sys_clk) disable iff (srst)
      (!(|pendVec) && !(|iusVec)) |=> (chainEnableOut == $past(chainEnableIn)))
      else $error("idle chain out does not follow chain in");

   // a low chain input always blocks everything below this device
   a_chain_in_low: assert property (@(posedge sys_clk) disable iff (srst)
      !chainEnableIn |=> !chainEnableOut)
      else $error("chain out high while chain in low");

   a_status_frozen: assert property (@(posedge sys_clk) disable iff (srst)
      (!hostBus.opcodeFetchN && $past(!hostBus.opcodeFetchN) && !$past(ackStart)
       && !$past(srst)) |-> (pendVec == $past(pendVec)))
      else $error("pending status changed during fetch strobe");

   a_vector_driven: assert property (@(posedge sys_clk) disable iff (srst)
      (ackStart && (|reqVec)) |=> (!busOeN && busDataOut == $past(ackVector)))
      else $error("vector not placed on bus at acknowledge");

   a_bus_released: assert property (@(posedge sys_clk) disable iff (srst)
      !ackNow |=> busOeN)
      else $error("bus driven outside acknowledge");

   a_ack_service: assert property (@(posedge sys_clk) disable iff (srst)
      (ackStart && (|reqVec)) |=> ($countones(iusVec) == $countones($past(iusVec)) + 1))
      else $error("acknowledge did not add one source in service");

   a_first_byte: assert property (@(posedge sys_clk) disable iff (srst)
      (fetchEnd && st_ff.fetchByte == OPC_RETURN_FIRST) |=> st_ff.returnFirstSeen)
      else $error("first return byte not recorded");

   a_return_clear: assert property (@(posedge sys_clk) disable iff (srst)
      (returnDone && chainEnableIn && (|iusVec)) // outer chain hands us the return
         |=> ($countones(iusVec) == $countones($past(iusVec)) - 1))
      else $error("return did not end exactly one service");

endmodule : dcil_top

// [sim/dcil_host_model.sv]
`timescale 1ns/10ps
module dcil_host_model
   import dcil_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // device bus drive
   input wire logic [7:0] busDataOut,
   input wire logic busOeN,
   // strobes and wire value
   output dcil_host_s hostBus
);
   logic fetchN = 1'b1;
   logic ioN = 1'b1;
   logic [7:0] hostData = 8'h00;
   // wire carries the vector while the device drives it
   assign hostBus = '{opcodeFetchN: fetchN, ioRequestN: ioN,
                      data: (busOeN === 1'b0) ? busDataOut : hostData};
   // one opcode fetch, three cycles of strobe
   task automatic fetch(input logic [7:0] opc);
      @(negedge sys_clk);
      fetchN = 1'b0;
      hostData = opc;
      repeat (3) @(negedge sys_clk);
      fetchN = 1'b1;
      hostData = ~opc; // released bus shows no stale byte
   endtask : fetch
   // acknowledge: fetch strobe first, io strobe later
   task automatic ack(output logic [7:0] vec, output logic oeN);
      @(negedge sys_clk);
      fetchN = 1'b0;
      repeat (2) @(negedge sys_clk);
      ioN = 1'b0;
      repeat (2) @(negedge sys_clk);
      vec = hostBus.data;
      oeN = busOeN;
      @(negedge sys_clk);
      fetchN = 1'b1;
      ioN = 1'b1;
   endtask : ack
endmodule : dcil_host_model

// [sim/tb_daisy_chain_interrupt_logic.sv]
`timescale 1ns/10ps
module tb_daisy_chain_interrupt_logic import dcil_pkg::*;;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic chainEnableIn = 1'b1; // top of chain held high
   logic [7:0] srcEvent = 8'h00;
   logic [7:0] vectorBase = 8'hA0;
   dcil_host_s hostBus;
   logic [7:0] busDataOut;
   logic busOeN;
   logic intN;
   logic chainEnableOut;
   int bad_count = 0;
   int tests_run = 0;
   dcil_top #(.NUM_SRC(8)) dut_u (.sys_clk(sys_clk), .srst(srst), .hostBus(hostBus),
      .busDataOut(busDataOut), .busOeN(busOeN), .intN(intN), .chainEnableIn(chainEnableIn),
      .chainEnableOut(chainEnableOut), .srcEvent(srcEvent), .vectorBase(vectorBase));
   dcil_host_model host_u (.sys_clk(sys_clk), .busDataOut(busDataOut), .busOeN(busOeN),
      .hostBus(hostBus));
   // shared clock with the host model
   initial forever #5 sys_clk = ~sys_clk;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk_bit(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_byte
   task automatic pulse(input int idx);
      @(negedge sys_clk);
      srcEvent[idx] = 1'b1;
      @(negedge sys_clk);
      srcEvent[idx] = 1'b0;
      repeat (3) @(negedge sys_clk);
   endtask : pulse
   task automatic ack_chk(input logic [2:0] idx);
      logic [7:0] vec;
      logic oeN;
      host_u.ack(vec, oeN);
      chk_bit("vector enable", 1'b0, oeN);
      chk_byte("vector", {vectorBase[7:3], idx}, vec);
      repeat (2) @(negedge sys_clk);
      chk_bit("bus release", 1'b1, busOeN);
   endtask : ack_chk
   task automatic ret();
      host_u.fetch(OPC_RETURN_FIRST);
      host_u.fetch(OPC_RETURN_SECOND);
      repeat (3) @(negedge sys_clk);
   endtask : ret
   task automatic wait_int();
      int n;
      n = 0;
      while (intN !== 1'b0 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
   endtask : wait_int
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_chain();
      chk_bit("int idle", 1'b1, intN);
      chainEnableIn = 1'b0;
      repeat (2) @(negedge sys_clk); // ripple through the registered chain
      chk_bit("chain low", 1'b0, chainEnableOut);
      chainEnableIn = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk_bit("chain high", 1'b1, chainEnableOut);
   endtask : t_chain
   task automatic t_request_ack();
      pulse(2);
      chk_bit("int request", 1'b0, intN);
      chk_bit("chain pending", 1'b0, chainEnableOut);
      ack_chk(3'h2);
      chk_bit("int after ack", 1'b1, intN);
      chk_bit("chain in service", 1'b0, chainEnableOut);
   endtask : t_request_ack
   task automatic t_nested_return();
      pulse(5);
      pulse(0);
      chk_bit("int nested", 1'b0, intN);
      ack_chk(3'h0);
      chk_bit("lower blocked", 1'b1, intN);
      host_u.fetch(OPC_RETURN_FIRST);
      host_u.fetch(8'h00);
      host_u.fetch(OPC_RETURN_SECOND);
      ret();
      chk_bit("one service ended", 1'b1, intN);
      ret();
      wait_int();
      chk_bit("lower released", 1'b0, intN);
      ack_chk(3'h5);
      ret();
      chk_bit("chain restored", 1'b1, chainEnableOut);
   endtask : t_nested_return
   task automatic t_freeze();
      fork
         host_u.fetch(8'h00);
         begin
            @(negedge sys_clk);
            srcEvent[3] = 1'b1;
            @(negedge sys_clk);
            srcEvent[3] = 1'b0;
            @(negedge sys_clk);
            @(negedge sys_clk); // last cycle of the strobe, intN would be low by now
            chk_bit("int frozen", 1'b1, intN);
         end
      join
      repeat (3) @(negedge sys_clk);
      chk_bit("int after fetch", 1'b0, intN);
      ack_chk(3'h3);
      ret();
   endtask : t_freeze
   task automatic t_pending_over();
      pulse(6);
      ack_chk(3'h6);
      pulse(1);
      chk_bit("higher pending", 1'b0, intN);
      ret();
      ack_chk(3'h1);
      ret();
      chk_bit("all ended", 1'b1, chainEnableOut);
      chk_bit("int clear", 1'b1, intN);
   endtask : t_pending_over
   initial begin
      repeat (2) @(negedge sys_clk);
      srst = 1'b0;
      t_chain();
      t_request_ack();
      t_nested_return();
      t_freeze();
      t_pending_over();
      test_done();
   end
   // hang guard, far beyond the roughly 170 cycles of the run
   initial begin
      #100000;
      bad_count++;
      test_done();
   end
endmodule : tb_daisy_chain_interrupt_logic
